// >>> gts_pkg.sv
`default_nettype none
package gts_pkg;

    // register offsets
    localparam logic [7:0] GTS_ADDR_STATUS   = 8'h00;
    localparam logic [7:0] GTS_ADDR_INT_MASK = 8'h01;
    localparam logic [7:0] GTS_ADDR_PIN_CFG  = 8'h02;
    localparam logic [7:0] GTS_ADDR_FIFO_CFG = 8'h06;
    localparam logic [7:0] GTS_ADDR_TSEL     = 8'h0B;
    localparam logic [7:0] GTS_ADDR_PIN1_EN  = 8'h4F;

    // field positions
    localparam int GTS_STAT_SMP_A     = 5;
    localparam int GTS_STAT_SMP_B     = 6;
    localparam int GTS_MASK_FIFO      = 8;
    localparam int GTS_CFG0_POL       = 0;
    localparam int GTS_CFG0_OD        = 1;
    localparam int GTS_CFG0_EN        = 2;
    localparam int GTS_CFG1_POL       = 8;
    localparam int GTS_CFG1_OD        = 9;
    localparam int GTS_PIN1_EN_BIT    = 6;
    localparam int GTS_FIFO_THR_LSB   = 8;
    localparam int GTS_FIFO_THR_MSB   = 13;
    localparam int GTS_SEL0_LSB       = 0;
    localparam int GTS_SEL1_LSB       = 8;

    // values after reset
    localparam logic [15:0] GTS_RST_INT_MASK = 16'h01FF;
    localparam logic [15:0] GTS_RST_PIN_CFG  = 16'h0000;
    localparam logic [5:0]  GTS_RST_FIFO_THR = 6'h00;
    localparam logic [15:0] GTS_RST_TSEL     = 16'h0000;

    // select codes
    typedef enum logic [4:0] {
        GTS_SEL_LEGACY  = 5'h00,
        GTS_SEL_IRQ     = 5'h01,
        GTS_SEL_WINDOW  = 5'h02,
        GTS_SEL_LED_A   = 5'h05,
        GTS_SEL_LED_B   = 5'h06,
        GTS_SEL_LED_AB  = 5'h07,
        GTS_SEL_DWR_A   = 5'h0C,
        GTS_SEL_DWR_B   = 5'h0D,
        GTS_SEL_DWR_AB  = 5'h0E,
        GTS_SEL_HALF    = 5'h0F,
        GTS_SEL_LOW     = 5'h10,
        GTS_SEL_HIGH    = 5'h11,
        GTS_SEL_OSC     = 5'h13
    } gts_sel_t;

    // timing events from the sequencer, all on mclk
    typedef struct packed {
        logic slotAEn;
        logic slotBEn;
        logic slotAStart;
        logic slotAEnd;
        logic slotBStart;
        logic slotBEnd;
        logic ledPulseA;
        logic ledPulseB;
        logic dataWrA;
        logic dataWrB;
    } gts_timing_t;

    // per-pin output stage configuration
    typedef struct packed {
        logic activeLow;
        logic openDrain;
        logic driveEn;
    } gts_pin_cfg_t;

endpackage
`default_nettype wire

// >>> gts_pin_stage.sv
`timescale 1ns/1ps
`default_nettype none
module gts_pin_stage
    import gts_pkg::*;
(
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // control
    input  wire gts_pin_cfg_t cfg,
    input  wire logic         asserted,
    // pin
    output logic              pinOut,
    output logic              pinOe
);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pinOut <= 1'b0;
            pinOe  <= 1'b0;
        end
        else
        begin
            pinOut <= asserted ^ cfg.activeLow;
            pinOe  <= cfg.driveEn & (~cfg.openDrain | asserted);
        end
    end

    a_pin_od_float: assert property (@(posedge mclk) disable iff (!rst_n)
        (cfg.openDrain && !asserted) |=> !pinOe)
        else $error("open-drain pin driven while deasserted");

endmodule
`default_nettype wire

// >>> gts_timing_select.sv
`timescale 1ns/1ps
`default_nettype none
module gts_timing_select
    import gts_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // register port
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWrData,
    output logic      [15:0] regRdData,
    // sequencer events and status
    input  wire gts_timing_t tim,
    input  wire logic        normalMode,
    input  wire logic [5:0]  fifoLevel,
    input  wire logic        legacySampleOut,
    // asynchronous 32 kHz oscillator
    input  wire logic        osc32k,
    // pins
    output logic             timingOutPinZero,
    output logic             timingOutPinZeroOe,
    output logic             timingOutPinOne,
    output logic             timingOutPinOneOe,
    output logic             irqLevel
);

    logic [1:0]   statSmp;
    logic [15:0]  intMask;
    logic [15:0]  pinCfg;
    logic [5:0]   fifoThr;
    logic         pin1DriveEn;
    logic [15:0]  tsel;
    logic         sampleWindow;
    logic         dataFlagA;
    logic         dataFlagB;
    logic         halfRateToggle;
    logic [2:0]   oscSync;
    logic         oscLevel;
    logic         firstStart;
    logic         lastEnd;
    logic         fifoHit;
    logic         legacyMode;
    logic [15:0]  next_rdData;
    logic [1:0]   assertedLvl;
    gts_pin_cfg_t cfg0;
    gts_pin_cfg_t cfg1;

    function automatic logic regHit(input logic [7:0] addr, input logic [7:0] want);
        regHit = (addr == want);
    endfunction

    // the first enabled slot opens the sample, the last enabled one closes it
    assign firstStart = tim.slotAEn ? tim.slotAStart : (tim.slotBEn & tim.slotBStart);
    assign lastEnd    = tim.slotBEn ? tim.slotBEnd   : (tim.slotAEn & tim.slotAEnd);
    assign fifoHit    = (fifoLevel >= fifoThr) & ~intMask[GTS_MASK_FIFO];
    assign irqLevel   = (statSmp[0] & ~intMask[GTS_STAT_SMP_A])
                      | (statSmp[1] & ~intMask[GTS_STAT_SMP_B])
                      | fifoHit;
    assign legacyMode = (tsel == 16'h0000);

    // --- register file ---
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            intMask     <= GTS_RST_INT_MASK;
            pinCfg      <= GTS_RST_PIN_CFG;
            fifoThr     <= GTS_RST_FIFO_THR;
            pin1DriveEn <= 1'b0;
            tsel        <= GTS_RST_TSEL;
        end
        else if (regWrEn)
        begin
            if (regHit(regAddr, GTS_ADDR_INT_MASK))
                intMask <= regWrData;
            else if (regHit(regAddr, GTS_ADDR_PIN_CFG))
                pinCfg <= regWrData;
            else if (regHit(regAddr, GTS_ADDR_FIFO_CFG))
                fifoThr <= regWrData[GTS_FIFO_THR_MSB:GTS_FIFO_THR_LSB];
            else if (regHit(regAddr, GTS_ADDR_TSEL))
                tsel <= regWrData;
            else if (regHit(regAddr, GTS_ADDR_PIN1_EN))
                pin1DriveEn <= regWrData[GTS_PIN1_EN_BIT];
        end
    end

    // sample interrupt status: write one to clear, a new sample wins
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            statSmp <= 2'b00;
        end
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (i == 0 ? tim.dataWrA : tim.dataWrB)
                begin
                    statSmp[i] <= 1'b1;
                end
                else if (regWrEn && regHit(regAddr, GTS_ADDR_STATUS)
                         && regWrData[GTS_STAT_SMP_A + i])
                begin
                    statSmp[i] <= 1'b0;
                end
            end
        end
    end

    always_comb
    begin
        next_rdData = 16'h0000;
        if (regHit(regAddr, GTS_ADDR_STATUS))
        begin
            next_rdData[GTS_STAT_SMP_A] = statSmp[0];
            next_rdData[GTS_STAT_SMP_B] = statSmp[1];
        end
        else if (regHit(regAddr, GTS_ADDR_INT_MASK))
            next_rdData = intMask;
        else if (regHit(regAddr, GTS_ADDR_PIN_CFG))
            next_rdData = pinCfg;
        else if (regHit(regAddr, GTS_ADDR_FIFO_CFG))
            next_rdData[GTS_FIFO_THR_MSB:GTS_FIFO_THR_LSB] = fifoThr;
        else if (regHit(regAddr, GTS_ADDR_TSEL))
            next_rdData = tsel;
        else if (regHit(regAddr, GTS_ADDR_PIN1_EN))
            next_rdData[GTS_PIN1_EN_BIT] = pin1DriveEn;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            regRdData <= 16'h0000;
        else if (regRdEn)
            regRdData <= next_rdData;
    end

    // --- timing sources ---
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sampleWindow <= 1'b0;
        end
        else if (firstStart)
        begin
            sampleWindow <= 1'b1;
        end
        else if (lastEnd)
        begin
            sampleWindow <= 1'b0;
        end
    end

    // data flags: set at slot end, the set wins over the new-sample clear
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dataFlagA <= 1'b0;
            dataFlagB <= 1'b0;
        end
        else
        begin
            dataFlagA <= tim.dataWrA | (dataFlagA & ~firstStart);
            dataFlagB <= tim.dataWrB | (dataFlagB & ~firstStart);
        end
    end

    // standby holds the toggle low so the first completed sample raises it
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            halfRateToggle <= 1'b0;
        end
        else if (!normalMode)
        begin
            halfRateToggle <= 1'b0;
        end
        else if (lastEnd)
        begin
            halfRateToggle <= ~halfRateToggle;
        end
    end

    // oscillator is asynchronous; a glitch-free copy needs two agreeing stages
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            oscSync  <= 3'b000;
            oscLevel <= 1'b0;
        end
        else
        begin
            oscSync <= {oscSync[1:0], osc32k};
            if (oscSync[1] == oscSync[2])
            begin
                oscLevel <= oscSync[2];
            end
        end
    end

    function automatic logic pickSource(input logic [4:0] code);
        case (code)
            GTS_SEL_IRQ:    pickSource = irqLevel;
            GTS_SEL_WINDOW: pickSource = sampleWindow;
            GTS_SEL_LED_A:  pickSource = tim.ledPulseA;
            GTS_SEL_LED_B:  pickSource = tim.ledPulseB;
            GTS_SEL_LED_AB: pickSource = tim.ledPulseA | tim.ledPulseB;
            GTS_SEL_DWR_A:  pickSource = dataFlagA;
            GTS_SEL_DWR_B:  pickSource = dataFlagB;
            GTS_SEL_DWR_AB: pickSource = dataFlagA | dataFlagB;
            GTS_SEL_HALF:   pickSource = halfRateToggle;
            GTS_SEL_LOW:    pickSource = 1'b0;
            GTS_SEL_HIGH:   pickSource = 1'b1;
            GTS_SEL_OSC:    pickSource = oscLevel;
            default:        pickSource = 1'b0;
        endcase
    endfunction

    always_comb
    begin
        if (legacyMode)
        begin
            assertedLvl[0] = irqLevel;
            assertedLvl[1] = legacySampleOut;
        end
        else
        begin
            assertedLvl[0] = pickSource(tsel[GTS_SEL0_LSB +: 5]);
            assertedLvl[1] = pickSource(tsel[GTS_SEL1_LSB +: 5]);
        end
    end

    assign cfg0 = '{activeLow: pinCfg[GTS_CFG0_POL], openDrain: pinCfg[GTS_CFG0_OD],
                    driveEn: pinCfg[GTS_CFG0_EN]};
    assign cfg1 = '{activeLow: pinCfg[GTS_CFG1_POL], openDrain: pinCfg[GTS_CFG1_OD],
                    driveEn: pin1DriveEn};

    gts_pin_stage uPinZero (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .cfg      (cfg0),
        .asserted (assertedLvl[0]),
        .pinOut   (timingOutPinZero),
        .pinOe    (timingOutPinZeroOe)
    );

    gts_pin_stage uPinOne (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .cfg      (cfg1),
        .asserted (assertedLvl[1]),
        .pinOut   (timingOutPinOne),
        .pinOe    (timingOutPinOneOe)
    );

    // --- checks ---
    sequence s_dataWrite;
        tim.dataWrA && !firstStart;
    endsequence

    sequence s_flagHeld;
        dataFlagA ##1 dataFlagA;
    endsequence

    a_legacy_irq: assert property (@(posedge mclk) disable iff (!rst_n)
        (legacyMode && !pinCfg[GTS_CFG0_POL]) |=> (timingOutPinZero == $past(irqLevel)))
        else $error("legacy pin zero does not follow interrupt");

    a_irq_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (tim.dataWrA && !intMask[GTS_STAT_SMP_A]) |=> irqLevel)
        else $error("unmasked slot A sample did not raise interrupt");

    a_window_open: assert property (@(posedge mclk) disable iff (!rst_n)
        firstStart |=> sampleWindow)
        else $error("sample window did not open");

    a_window_close: assert property (@(posedge mclk) disable iff (!rst_n)
        (lastEnd && !firstStart) |=> !sampleWindow)
        else $error("sample window did not close");

    a_data_flag_set: assert property (@(posedge mclk) disable iff (!rst_n)
        s_dataWrite |=> s_flagHeld or (dataFlagA ##1 (!dataFlagA && $past(firstStart))))
        else $error("slot A data flag not held after write");

    a_data_flag_clr: assert property (@(posedge mclk) disable iff (!rst_n)
        (firstStart && !tim.dataWrA) |=> !dataFlagA)
        else $error("slot A data flag survived new sample");

    a_half_standby: assert property (@(posedge mclk) disable iff (!rst_n)
        !normalMode |=> !halfRateToggle)
        else $error("half-rate toggle not low in standby");

    a_half_toggle: assert property (@(posedge mclk) disable iff (!rst_n)
        (normalMode && lastEnd) |=> (halfRateToggle != $past(halfRateToggle)))
        else $error("half-rate toggle missed a sample");

    a_const_high: assert property (@(posedge mclk) disable iff (!rst_n)
        (tsel[GTS_SEL0_LSB +: 5] == GTS_SEL_HIGH && !pinCfg[GTS_CFG0_POL])
        |=> timingOutPinZero)
        else $error("constant high not driven on pin zero");

    a_reserved_low: assert property (@(posedge mclk) disable iff (!rst_n)
        (tsel[GTS_SEL1_LSB +: 5] == 5'h1F && !pinCfg[GTS_CFG1_POL])
        |=> !timingOutPinOne)
        else $error("reserved code did not give inactive level");

    a_fifo_thr: assert property (@(posedge mclk) disable iff (!rst_n)
        (fifoLevel >= fifoThr && !intMask[GTS_MASK_FIFO]) |-> irqLevel)
        else $error("fifo threshold did not raise interrupt");

endmodule
`default_nettype wire

// >>> gts_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module gts_far_side
(
    // pins of the block
    input  wire logic pinZero,
    input  wire logic pinZeroOe,
    input  wire logic pinOne,
    input  wire logic pinOneOe,
    // board level seen by host and peripheral, pulled up when released
    output logic      busZero,
    output logic      busOne
);
    assign busZero = pinZeroOe ? pinZero : 1'b1;
    assign busOne  = pinOneOe ? pinOne : 1'b1;
endmodule
`default_nettype wire

// >>> tb_gts_timing_select.sv
`timescale 1ns/1ps
`default_nettype none
module tb_gts_timing_select;
    import gts_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        regWrEn = 1'b0;
    logic        regRdEn = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [15:0] regWrData = 16'h0000;
    logic [15:0] regRdData;
    gts_timing_t tim = '0;
    logic        normalMode = 1'b0;
    logic [5:0]  fifoLevel = 6'h00;
    logic        legacySampleOut = 1'b0;
    logic        osc32k = 1'b0;
    logic        p0, p0Oe, p1, p1Oe, irqLevel, bus0, bus1;
    // bench model state
    logic [15:0] mTsel = 16'h0000, mMask = 16'h01FF, mCfg = 16'h0000;
    logic [5:0]  mThr = 6'h00, thr;
    logic        mEn1 = 0, mWin = 0, mDA = 0, mDB = 0, mTog = 0, mStA = 0, mStB = 0;
    int          errors = 0;
    int          num_checks = 0;
    logic [15:0] cfgs [4] = '{16'h0004, 16'h0105, 16'h0206, 16'h0307};
    logic [4:0]  codes [4] = '{5'h10, 5'h11, 5'h03, 5'h1F};
    logic [15:0] tsels [5] = '{16'h0F02, 16'h0E0C, 16'h0D05, 16'h0706, 16'h020F};

    always #10 mclk = ~mclk;
    always #15625 osc32k = ~osc32k;

    gts_timing_select u_dut (
        .mclk               (mclk),
        .rst_n              (rst_n),
        .regWrEn            (regWrEn),
        .regRdEn            (regRdEn),
        .regAddr            (regAddr),
        .regWrData          (regWrData),
        .regRdData          (regRdData),
        .tim                (tim),
        .normalMode         (normalMode),
        .fifoLevel          (fifoLevel),
        .legacySampleOut    (legacySampleOut),
        .osc32k             (osc32k),
        .timingOutPinZero   (p0),
        .timingOutPinZeroOe (p0Oe),
        .timingOutPinOne    (p1),
        .timingOutPinOneOe  (p1Oe),
        .irqLevel           (irqLevel)
    );

    gts_far_side u_far (
        .pinZero   (p0),
        .pinZeroOe (p0Oe),
        .pinOne    (p1),
        .pinOneOe  (p1Oe),
        .busZero   (bus0),
        .busOne    (bus1)
    );

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic mIrq();
        return (mStA & ~mMask[5]) | (mStB & ~mMask[6]) | ((fifoLevel >= mThr) & ~mMask[8]);
    endfunction

    function automatic logic expAsr(input logic [4:0] c);
        case (c)
            5'h01: return mIrq();
            5'h02: return mWin;
            5'h05: return tim.ledPulseA;
            5'h06: return tim.ledPulseB;
            5'h07: return tim.ledPulseA | tim.ledPulseB;
            5'h0C: return mDA;
            5'h0D: return mDB;
            5'h0E: return mDA | mDB;
            5'h0F: return mTog;
            5'h11: return 1'b1;
            5'h13: return osc32k;
            default: return 1'b0;
        endcase
    endfunction

    task automatic chkPins();
        logic a0;
        logic a1;
        logic oe0;
        logic oe1;
        a0 = (mTsel == 16'h0000) ? mIrq() : expAsr(mTsel[4:0]);
        a1 = (mTsel == 16'h0000) ? legacySampleOut : expAsr(mTsel[12:8]);
        oe0 = mCfg[2] & (~mCfg[1] | a0);
        oe1 = mEn1 & (~mCfg[9] | a1);
        chk("irqLevel", 16'(mIrq()), 16'(irqLevel));
        chk("pin0 oe", 16'(oe0), 16'(p0Oe));
        chk("pin0 bus", 16'(oe0 ? a0 ^ mCfg[0] : 1'b1), 16'(bus0));
        chk("pin1 oe", 16'(oe1), 16'(p1Oe));
        chk("pin1 bus", 16'(oe1 ? a1 ^ mCfg[8] : 1'b1), 16'(bus1));
    endtask

    task automatic settle();
        repeat (3) @(negedge mclk);
        chkPins();
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge mclk);
        regWrEn = 1'b0;
        case (a)
            GTS_ADDR_STATUS: {mStB, mStA} = {mStB, mStA} & ~d[6:5];
            GTS_ADDR_INT_MASK: mMask = d;
            GTS_ADDR_PIN_CFG: mCfg = d;
            GTS_ADDR_FIFO_CFG: mThr = d[13:8];
            GTS_ADDR_TSEL: mTsel = d;
            GTS_ADDR_PIN1_EN: mEn1 = d[6];
            default: ;
        endcase
        @(negedge mclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge mclk);
        regRdEn = 1'b0;
        @(negedge mclk);
        chk($sformatf("reg %h", a), exp, regRdData);
    endtask

    // one enabled slot: LED pulses, then end with data stored
    task automatic slotBody(input logic isB, input logic last);
        tim.slotBStart = isB & tim.slotAEn;
        @(negedge mclk);
        tim.slotBStart = 1'b0;
        tim.ledPulseA = !isB;
        tim.ledPulseB = isB;
        settle();
        tim.ledPulseA = 1'b0;
        tim.ledPulseB = 1'b0;
        tim.slotAEnd = !isB;
        tim.slotBEnd = isB;
        tim.dataWrA = !isB;
        tim.dataWrB = isB;
        @(negedge mclk);
        {tim.slotAEnd, tim.slotBEnd, tim.dataWrA, tim.dataWrB} = 4'h0;
        mDA |= !isB;
        mDB |= isB;
        mStA |= !isB;
        mStB |= isB;
        if (last)
        begin
            mWin = 1'b0;
            mTog = normalMode & ~mTog;
        end
        settle();
    endtask

    task automatic runSample(input logic a, input logic b);
        tim.slotAEn = a;
        tim.slotBEn = b;
        tim.slotAStart = a;
        tim.slotBStart = !a;
        @(negedge mclk);
        tim.slotAStart = 1'b0;
        tim.slotBStart = 1'b0;
        mWin = 1'b1;
        mDA = 1'b0;
        mDB = 1'b0;
        settle();
        if (a)
            slotBody(1'b0, !b);
        if (b)
            slotBody(1'b1, 1'b1);
    endtask

    task automatic waitOsc();
        logic o;
        o = osc32k;
        for (int n = 0; osc32k === o; n++)
        begin
            if (n > 2000)
            begin
                errors++;
                test_done();
            end
            @(negedge mclk);
        end
    endtask

    task automatic endTest(input string name);
        $display("test %s ended, checks %0d errors %0d", name, num_checks, errors);
    endtask

    initial
    begin
        void'($urandom(91));
        repeat (5) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        rd(GTS_ADDR_INT_MASK, GTS_RST_INT_MASK);
        rd(GTS_ADDR_TSEL, GTS_RST_TSEL);
        rd(GTS_ADDR_PIN_CFG, GTS_RST_PIN_CFG);
        wr(8'h20, 16'hFFFF);
        rd(8'h20, 16'h0000);
        chkPins();
        endTest("reset");
        wr(GTS_ADDR_PIN1_EN, 16'h0040);
        foreach (cfgs[i])
        begin
            wr(GTS_ADDR_PIN_CFG, cfgs[i]);
            rd(GTS_ADDR_PIN_CFG, cfgs[i]);
            foreach (codes[j])
            begin
                wr(GTS_ADDR_TSEL, {3'h0, codes[j], 3'h0, codes[(j + 1) % 4]});
                settle();
            end
        end
        endTest("levels");
        wr(GTS_ADDR_PIN_CFG, 16'h0004);
        foreach (tsels[i])
        begin
            wr(GTS_ADDR_TSEL, tsels[i]);
            settle();
            normalMode = 1'b1;
            runSample(1'b1, 1'b0);
            runSample(1'b1, 1'b1);
            runSample(1'b0, 1'b1);
        end
        normalMode = 1'b0;
        mTog = 1'b0;
        settle();
        normalMode = 1'b1;
        runSample(1'b0, 1'b1);
        endTest("events");
        wr(GTS_ADDR_STATUS, 16'h0060);
        wr(GTS_ADDR_TSEL, 16'h1001);
        wr(GTS_ADDR_INT_MASK, 16'h01DF);
        runSample(1'b1, 1'b1);
        rd(GTS_ADDR_STATUS, 16'h0060);
        wr(GTS_ADDR_STATUS, 16'h0020);
        settle();
        wr(GTS_ADDR_INT_MASK, 16'h01BF);
        settle();
        thr = 6'($urandom_range(62, 1));
        wr(GTS_ADDR_FIFO_CFG, {2'h0, thr, 8'h00});
        rd(GTS_ADDR_FIFO_CFG, {2'h0, thr, 8'h00});
        wr(GTS_ADDR_INT_MASK, 16'h00FF);
        for (int k = -1; k < 2; k++)
        begin
            fifoLevel = 6'(int'(thr) + k);
            settle();
        end
        endTest("interrupt");
        wr(GTS_ADDR_TSEL, 16'h0000);
        repeat (4)
        begin
            legacySampleOut = 1'($urandom);
            fifoLevel = 6'($urandom);
            settle();
        end
        wr(GTS_ADDR_TSEL, 16'h1313);
        repeat (4)
        begin
            waitOsc();
            repeat (6) @(negedge mclk);
            settle();
        end
        endTest("legacy and oscillator");
        test_done();
    end
endmodule
`default_nettype wire
